// file: rtl/edge_interrupt_and_context_save.v
`timescale 1ns/100ps
`default_nettype none
`include "irq_consts.vh"

// Behaviour
// RL1 - Timer wrap to zero requests interrupt when enabled
// RL2 - Eight edge sources, one per port pin
// RL3 - Enable bit zero enables the pin
// RL4 - Reset loads all ones into enable, edge
// RL5 - Edge bit one falling, zero rising
// RL6 - Detected edge sets matching pending bit
// RL7 - Software clears pending before enabling pins
// RL8 - No priority, one interrupt at a time
// RL9 - Acknowledge blocks entry until return
// RL10 - Push PC, save file select, status, W
// RL11 - Clear page bits after status saved
// RL12 - Interrupt stack separate from call stack
// RL13 - Entry loads program counter with zero
// RL14 - Routine clears handled pending bit
// RL15 - Edge in service sets pending, no entry
// RL16 - Return restores PC and shadow registers
// RL17 - Second return also adds literal to timer
// RL18 - Either return re-enables interrupt entry
// RL19 - Pending one means edge since cleared
// RL20 - Request on new pending while enabled, idle
module edge_interrupt_and_context_save (
	input wire clk, // Core clock
	input wire resetn, // Async reset, active low
	input wire ce, // Clock enable
	input wire [7:0] port_pins, // Port B pin levels
	input wire [7:0] rollover_timer, // Timer count now
	input wire timer_irq_en, // Timer interrupt enable (option bit)
	input wire boundary, // Instruction boundary pulse
	input wire [`PC_W-1:0] pc_in, // Program counter now
	input wire [7:0] file_select_in, // File select reg now
	input wire [7:0] status_in, // Status reg now
	input wire [7:0] w_in, // Working reg now
	input wire irq_return, // Plain return pulse
	input wire irq_return_add_timer, // Return with timer add pulse
	input wire [7:0] literal, // Literal for timer add
	input wire [1:0] reg_sel, // Pin register select
	input wire reg_wr, // Write strobe
	input wire [7:0] reg_wdata, // Write data
	output reg [7:0] reg_rdata, // Read data
	output reg irq_take, // Entry pulse to sequencer
	output reg in_service, // Interrupt in service
	output reg pc_load, // Load program counter pulse
	output reg [`PC_W-1:0] pc_out, // New program counter
	output reg ctx_load, // Load file select, status, W pulse
	output reg [7:0] file_select_out, // File select to load
	output reg [7:0] status_out, // Status to load
	output reg [7:0] w_out, // W to load
	output reg timer_load, // Load timer pulse
	output reg [7:0] timer_out, // Timer value to load
	output reg [7:0] pin_irq_enable, // Enable register
	output reg [7:0] pin_edge_select, // Edge select register
	output reg [7:0] pin_irq_pending // Pending register
);

	// Service sequencing states
	localparam [1:0] ST_IDLE = 2'b00;
	localparam [1:0] ST_ARMED = 2'b01;
	localparam [1:0] ST_SERVICE = 2'b10;

	// Pin and timer history for edge and wrap detection
	reg [7:0] pins_last_ff;
	reg [7:0] timer_last_ff;
	// Service state and its next value
	reg [1:0] state_ff;
	reg [1:0] nxt_state;
	// One-entry interrupt stack and context shadows
	reg [`PC_W-1:0] irq_stack_ff;
	reg [7:0] fsr_shadow_ff;
	reg [7:0] status_shadow_ff;
	reg [7:0] w_shadow_ff;
	// Events seen in the current cycle
	wire [7:0] edge_hit;
	wire [7:0] new_pend;
	wire timer_wrap;
	wire pin_req;
	wire any_ret;
	wire entry_go;
	wire return_go;
	// Register port write decodes
	wire wr_pending;
	wire wr_edge;
	wire wr_enable;
	// Next values of the pin registers and read port
	reg [7:0] nxt_pending;
	reg [7:0] nxt_edge;
	reg [7:0] nxt_enable;
	reg [7:0] nxt_rdata;

	// Per pin edge detect by selected polarity
	// RL5 edge polarity select
	function [7:0] edges;
		input [7:0] last;
		input [7:0] now;
		input [7:0] sel;
		begin
			edges = (sel & last & ~now) | (~sel & ~last & now);
		end
	endfunction

	// Write strobe for one register select code
	function sel_write;
		input wr;
		input [1:0] sel;
		input [1:0] code;
		begin
			sel_write = wr && (sel == code);
		end
	endfunction

	// Status byte with the page select field cleared
	// Page bits sit at the top of the status byte
	function [7:0] page_clear;
		input [7:0] status;
		begin
			page_clear = {{(`PAGE_MSB-`PAGE_LSB+1){1'b0}}, status[`PAGE_LSB-1:0]};
		end
	endfunction

	// RL2 eight pin sources
	assign edge_hit = edges(pins_last_ff, port_pins, pin_edge_select);
	// RL20 newly pending enabled pin
	assign new_pend = edge_hit & ~pin_irq_pending & ~pin_irq_enable;
	assign pin_req = |new_pend;
	// RL1 timer wrap request
	// Wrap is maximum last cycle and zero now
	assign timer_wrap = timer_irq_en && (timer_last_ff == `TIMER_MAX) && (rollover_timer == `TIMER_ZERO);
	assign any_ret = irq_return | irq_return_add_timer;

	// Register port write decodes
	assign wr_pending = sel_write(reg_wr, reg_sel, `SEL_PENDING);
	assign wr_edge = sel_write(reg_wr, reg_sel, `SEL_EDGE);
	assign wr_enable = sel_write(reg_wr, reg_sel, `SEL_ENABLE);

	// Boundary matters only while a request is armed
	// RL9 entry only when armed
	assign entry_go = (state_ff == ST_ARMED) && boundary;
	// RL18 either return ends service
	assign return_go = (state_ff == ST_SERVICE) && any_ret;

	// Next pin register values and read data
	always @* begin
		// RL6 set wins over clear
		nxt_pending = (wr_pending ? reg_wdata : pin_irq_pending) | edge_hit;
		nxt_edge = wr_edge ? reg_wdata : pin_edge_select;
		// RL3 zero enables pin
		nxt_enable = wr_enable ? reg_wdata : pin_irq_enable;
		case (reg_sel)
			`SEL_PENDING: begin
				nxt_rdata = pin_irq_pending;
			end
			`SEL_EDGE: begin
				nxt_rdata = pin_edge_select;
			end
			`SEL_ENABLE: begin
				nxt_rdata = pin_irq_enable;
			end
			default: begin
				nxt_rdata = 8'h00;
			end
		endcase
	end

	// Service state transitions
	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				// RL8 one request at a time
				if (timer_wrap || pin_req) begin
					nxt_state = ST_ARMED;
				end
			end
			ST_ARMED: begin
				// Request latched, wait for an instruction boundary
				if (boundary) begin
					nxt_state = ST_SERVICE;
				end
			end
			ST_SERVICE: begin
				// RL15 requests in service dropped
				// A timer wrap in service is lost, it has no flag
				if (any_ret) begin
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// Pin and timer history; pins are taken as synchronous to clk
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pins_last_ff <= 8'h00;
			timer_last_ff <= 8'h00;
		end else if (ce) begin
			pins_last_ff <= port_pins;
			timer_last_ff <= rollover_timer;
		end
	end

	// Pin registers and read port
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			// RL4 reset to all ones
			pin_irq_enable <= `PIN_IRQ_ENABLE_RST;
			pin_edge_select <= `PIN_EDGE_SELECT_RST;
			// Cleared here although software must not rely on it
			pin_irq_pending <= 8'h00;
			reg_rdata <= 8'h00;
		end else if (ce) begin
			// RL19 pending holds until cleared
			pin_irq_pending <= nxt_pending;
			// Edge select and enable take writes at once
			pin_edge_select <= nxt_edge;
			pin_irq_enable <= nxt_enable;
			reg_rdata <= nxt_rdata;
		end
	end

	// Service state; in service flag straight from a flop
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_ff <= ST_IDLE;
			in_service <= 1'b0;
		end else if (ce) begin
			state_ff <= nxt_state;
			in_service <= (nxt_state == ST_SERVICE);
		end
	end

	// One-entry interrupt stack and shadows, written only at entry
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq_stack_ff <= `IRQ_VECTOR;
			fsr_shadow_ff <= 8'h00;
			status_shadow_ff <= 8'h00;
			w_shadow_ff <= 8'h00;
		end else if (ce && entry_go) begin
			// RL10 push PC and context
			// RL12 own one-entry stack
			irq_stack_ff <= pc_in;
			fsr_shadow_ff <= file_select_in;
			status_shadow_ff <= status_in;
			w_shadow_ff <= w_in;
		end
	end

	// Load pulses to the sequencer, one clock-enabled cycle each; held while ce is low
	// Entry needs the armed state and return needs service, so never both
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq_take <= 1'b0;
			pc_load <= 1'b0;
			ctx_load <= 1'b0;
			timer_load <= 1'b0;
		end else if (ce) begin
			irq_take <= entry_go;
			pc_load <= entry_go || return_go;
			ctx_load <= entry_go || return_go;
			// RL17 timer add on return
			timer_load <= return_go && irq_return_add_timer;
		end
	end

	// Values presented with the load pulses; held until the next load
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pc_out <= `IRQ_VECTOR;
			file_select_out <= 8'h00;
			status_out <= 8'h00;
			w_out <= 8'h00;
			timer_out <= 8'h00;
		end else if (ce) begin
			if (entry_go) begin
				// RL13 vector zero
				pc_out <= `IRQ_VECTOR;
				file_select_out <= file_select_in;
				// RL11 clear page bits
				status_out <= page_clear(status_in);
				w_out <= w_in;
			end else if (return_go) begin
				// RL16 restore from shadows
				pc_out <= irq_stack_ff;
				file_select_out <= fsr_shadow_ff;
				status_out <= status_shadow_ff;
				w_out <= w_shadow_ff;
			end
			// Timer sum wraps at eight bits like the counter itself
			if (return_go && irq_return_add_timer) begin
				timer_out <= rollover_timer + literal;
			end
		end
	end

endmodule
`default_nettype wire

// file: pkg/irq_consts.vh
`ifndef IRQ_CONSTS_VH
`define IRQ_CONSTS_VH
// Reset values of the pin interrupt registers
`define PIN_IRQ_ENABLE_RST 8'hff
`define PIN_EDGE_SELECT_RST 8'hff
// Interrupt vector and program counter width
`define IRQ_VECTOR 11'h000
`define PC_W 11
// Page select bit positions inside the status byte
`define PAGE_LSB 5
`define PAGE_MSB 7
// Timer wrap values
`define TIMER_MAX 8'hff
`define TIMER_ZERO 8'h00
// Register selects for the pin register port
`define SEL_PENDING 2'h1
`define SEL_EDGE 2'h2
`define SEL_ENABLE 2'h3
`endif

// file: tb/edge_irq_chk.sv
`timescale 1ns/100ps
`default_nettype none
module edge_irq_chk(
	input wire clk, resetn, ce, boundary, irq_return, irq_return_add_timer, // In
	input wire irq_take, in_service, pc_load, ctx_load, timer_load, // Out
	input wire [10:0] pc_out, // PC
	input wire [7:0] status_out // Status
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence s_go; pc_load && ctx_load && pc_out == 11'h000; endsequence
	property p_e; irq_take |-> s_go ##0 status_out[7:5] == 3'h0; endproperty
	a_e: assert property (p_e) else $error("entry");
	property p_b; irq_take |=> in_service; endproperty
	a_b: assert property (p_b) else $error("block");
	property p_o; in_service && ce |=> !irq_take; endproperty
	a_o: assert property (p_o) else $error("nested");
	property p_d; $rose(irq_take) |-> $past(boundary && ce); endproperty
	a_d: assert property (p_d) else $error("boundary");
	property p_r; in_service && ce && irq_return |=> !in_service && pc_load; endproperty
	a_r: assert property (p_r) else $error("return");
	property p_t; in_service && ce && irq_return_add_timer |=> timer_load; endproperty
	a_t: assert property (p_t) else $error("add");
	property p_i; !in_service && ce |=> !timer_load; endproperty
	a_i: assert property (p_i) else $error("stray");
	property p_c; pc_load |-> ctx_load; endproperty
	a_c: assert property (p_c) else $error("context");
endmodule
bind edge_interrupt_and_context_save edge_irq_chk edge_irq_chk_i(.clk(clk), .resetn(resetn), .ce(ce),
	.boundary(boundary), .irq_return(irq_return), .irq_return_add_timer(irq_return_add_timer),
	.irq_take(irq_take), .in_service(in_service), .pc_load(pc_load), .ctx_load(ctx_load),
	.timer_load(timer_load), .pc_out(pc_out), .status_out(status_out));
`default_nettype wire

// file: tb/core_model.sv
`timescale 1ns/100ps
`default_nettype none
// Core stand-in: random context, late returns
module core_model(
	input wire logic clk, irq_take, in_service, // Block
	output logic boundary = 1'b0, irq_return = 1'b0, irq_return_add_timer = 1'b0, // Strobes
	output logic [10:0] pc_in = 11'h000, // PC
	output logic [7:0] file_select_in = 8'h00, status_in = 8'h00, w_in = 8'h00 // Context
);
	int seed = 32'h6707;
	always @(negedge clk) begin
		{pc_in, file_select_in, status_in, w_in, boundary} <= 36'({$random(seed), $random(seed)});
		{irq_return, irq_return_add_timer} <= in_service && !irq_take && seed[1] ? {seed[0], !seed[0]} : 2'h0;
	end
endmodule
`default_nettype wire

// file: tb/test_edge_interrupt_and_context_save.sv
`timescale 1ns/100ps
`default_nettype none
module test_edge_interrupt_and_context_save;
	logic clk = 1'b0, resetn = 1'b0, ce = 1'b1, timer_irq_en = 1'b0, reg_wr = 1'b0;
	logic [7:0] port_pins = 8'h00, rollover_timer = 8'h00, literal = 8'h00, reg_wdata = 8'h00;
	logic [1:0] reg_sel = 2'h3;
	wire boundary, irq_return, irq_return_add_timer, irq_take, in_service, pc_load, ctx_load, timer_load;
	wire [10:0] pc_in, pc_out;
	wire [7:0] file_select_in, status_in, w_in, reg_rdata, file_select_out, status_out, w_out, timer_out;
	wire [7:0] pin_irq_enable, pin_edge_select, pin_irq_pending;
	int seed = 32'h6707, errors = 0, total_checks = 0, cycles = 0, takes = 0, n;
	logic [34:0] cq[$];
	logic take_d = 1'b0, load_d = 1'b0;
	// Clock, block and core
	always #5 clk = ~clk;
	edge_interrupt_and_context_save edge_interrupt_and_context_save_i(.clk(clk), .resetn(resetn), .ce(ce),
		.port_pins(port_pins), .rollover_timer(rollover_timer), .timer_irq_en(timer_irq_en), .boundary(boundary),
		.pc_in(pc_in), .file_select_in(file_select_in), .status_in(status_in), .w_in(w_in),
		.irq_return(irq_return), .irq_return_add_timer(irq_return_add_timer), .literal(literal),
		.reg_sel(reg_sel), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq_take(irq_take),
		.in_service(in_service), .pc_load(pc_load), .pc_out(pc_out), .ctx_load(ctx_load),
		.file_select_out(file_select_out), .status_out(status_out), .w_out(w_out), .timer_load(timer_load),
		.timer_out(timer_out), .pin_irq_enable(pin_irq_enable), .pin_edge_select(pin_edge_select),
		.pin_irq_pending(pin_irq_pending));
	core_model core_model_i(.clk(clk), .irq_take(irq_take), .in_service(in_service), .boundary(boundary),
		.irq_return(irq_return), .irq_return_add_timer(irq_return_add_timer), .pc_in(pc_in),
		.file_select_in(file_select_in), .status_in(status_in), .w_in(w_in));
	task chk(input logic ok, input string m);
		total_checks++;
		if (ok !== 1'b1) begin
			errors++;
			$display("mismatch %0t %s", $time, m);
		end
	endtask
	task results;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task wr(input logic [1:0] s, input logic [7:0] d);
		@(negedge clk);
		{reg_sel, reg_wdata, reg_wr} <= {s, d, 1'b1};
		@(negedge clk);
		reg_wr <= 1'b0;
	endtask
	// Timer, context note at entry, timeout
	always @(negedge clk) begin
		rollover_timer <= rollover_timer + 8'h01;
		if (irq_take && !take_d)
			cq.push_back({pc_in, file_select_in, status_in, w_in});
		if (++cycles > 9000) begin
			errors++;
			results();
		end
	end
	// Watcher compares each restore with the oldest note
	always @(negedge clk) begin
		take_d <= irq_take;
		load_d <= pc_load;
		takes += irq_take && !take_d;
		if (irq_take && !take_d)
			chk({pc_out, file_select_out, status_out, w_out} === {11'h000, file_select_in, 3'h0, status_in[4:0], w_in}, "entry");
		if (pc_load && !load_d && !irq_take)
			chk(cq.size() > 0 && {pc_out, file_select_out, status_out, w_out} === cq.pop_front(), "restore");
		if (timer_load && !load_d)
			chk(timer_out === rollover_timer + literal, "add");
	end
	// Main sequence
	initial begin
		repeat (10) @(negedge clk);
		resetn <= 1'b1;
		@(negedge clk);
		chk(pin_irq_enable === 8'hff && pin_edge_select === 8'hff && reg_rdata === 8'hff, "reset");
		wr(2'h2, 8'h0f);
		wr(2'h1, 8'h00);
		port_pins <= 8'hff;
		repeat (2) @(negedge clk);
		chk(pin_irq_pending === 8'hf0, "edge");
		wr(2'h1, 8'h00);
		wr(2'h3, 8'h00);
		repeat (4000) begin
			@(negedge clk);
			{ce, port_pins, literal, timer_irq_en} <= {|3'($random(seed)), 16'($random(seed)), 1'b1};
			{reg_sel, reg_wdata, reg_wr} <= {2'h1, 8'h00, in_service & seed[4]};
		end
		@(negedge clk) ce <= 1'b1;
		wr(2'h3, 8'hff);
		{ce, timer_irq_en} <= 2'b10;
		repeat (20) @(negedge clk);
		n = takes;
		repeat (600) @(negedge clk) port_pins <= 8'($random(seed));
		chk(takes == n, "masked");
		timer_irq_en <= 1'b1;
		repeat (700) @(negedge clk);
		chk(takes - n > 1, "timer");
		results();
	end
endmodule
`default_nettype wire
